// File: logic/tmb_pkg.sv
// Summary of operation
// - run bit shows counting; writes ignored
// - debug halt without run-in-debug bit freezes count and events
// - run-in-debug bit keeps timer running halted
// - one shared buffer byte, software readable/writable
// - count low byte at base, high next
// - count register write beats internal update
// - capture/compare low at base, high next
// - capture loads counter value into register
// - compare value is top in periodic modes
// - pwm: low byte period, high byte duty
// - capture flag cleared by read or one
package tmb_pkg;
  localparam logic [7:0] TMB_OFS_FLAGS = 8'h06;
  localparam logic [7:0] TMB_OFS_STATUS = 8'h07;
  localparam logic [7:0] TMB_OFS_DBG = 8'h08;
  localparam logic [7:0] TMB_OFS_TEMP = 8'h09;
  localparam logic [7:0] TMB_OFS_CNT_L = 8'h0A;
  localparam logic [7:0] TMB_OFS_CNT_H = 8'h0B;
  localparam logic [7:0] TMB_OFS_CAPTURE_COMPARE_VALUE_L = 8'h0C;
  localparam logic [7:0] TMB_OFS_CAPTURE_COMPARE_VALUE_H = 8'h0D;
  localparam int TMB_BIT_RUN = 0;
  localparam int TMB_BIT_RUN_IN_DEBUG_HALT = 0;
  localparam int TMB_BIT_CAPTURE_FLAG = 0;
  localparam logic [7:0] TMB_RST_BYTE = 8'h00;
  localparam logic [15:0] TMB_RST_WORD = 16'h0000;
  localparam logic [15:0] TMB_ONE = 16'h0001;

  typedef enum logic [2:0] {
    TMB_PERIODIC,
    TMB_TIMEOUT,
    TMB_CAPTURE_FLAG_EVENT,
    TMB_CAPTURE_FLAG_FREQ,
    TMB_CAPTURE_FLAG_PW,
    TMB_CAPTURE_FLAG_FRQPW,
    TMB_SINGLE_SHOT,
    TMB_PWM8
  } tmb_mode_t;

  typedef enum logic [1:0] {
    TMB_PH_IDLE,
    TMB_PH_FIRST,
    TMB_PH_SECOND,
    TMB_PH_DONE
  } tmb_phase_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmb_req_t;
endpackage

// File: logic/tmb_timer.sv
`timescale 1ns/100ps
module tmb_timer (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire tmb_pkg::tmb_req_t req_in,
  input wire tmb_pkg::tmb_mode_t mode_in,
  input wire logic enable_in,
  input wire logic capture_event_in,
  input wire logic debug_halt_in,
  output logic [7:0] rdata_out,
  output logic run_out,
  output logic capture_flag_out,
  output logic pwm_out,
  output logic top_pulse_out
);
  import tmb_pkg::*;

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] capture_compare_value_r;
  logic [7:0] temp_r;
  logic [7:0] rdata_r;
  logic run_in_debug_halt_r;
  logic run_r;
  logic run_nxt;
  logic flag_r;
  logic ev_prev_r;
  logic pwm_r;
  logic top_r;
  tmb_phase_t phase_r;

  logic frozen;
  logic tick;
  logic pos;
  logic neg;
  logic at_top;
  logic pwm_wrap;
  logic capture_flag_mode;
  logic top_mode;
  logic cap_now;
  logic restart;
  logic flag_set;
  logic flag_clr;
  logic wr_cnt;
  logic wr_capture_compare_value;

  // events and counting are both gated, so a halted timer sees nothing
  assign frozen = debug_halt_in & ~run_in_debug_halt_r;
  assign pos = ~frozen & capture_event_in & ~ev_prev_r;
  assign neg = ~frozen & ~capture_event_in & ev_prev_r;
  assign tick = run_r & ~frozen;
  assign at_top = cnt_r == capture_compare_value_r;
  assign pwm_wrap = cnt_r[7:0] == capture_compare_value_r[7:0];
  assign capture_flag_mode = mode_in inside {TMB_CAPTURE_FLAG_EVENT, TMB_CAPTURE_FLAG_FREQ, TMB_CAPTURE_FLAG_PW,
    TMB_CAPTURE_FLAG_FRQPW};
  assign top_mode = mode_in inside {TMB_PERIODIC, TMB_TIMEOUT, TMB_SINGLE_SHOT};
  assign wr_cnt = req_in.wr & (req_in.addr == TMB_OFS_CNT_L);
  assign wr_capture_compare_value = req_in.wr & (req_in.addr inside {TMB_OFS_CAPTURE_COMPARE_VALUE_L, TMB_OFS_CAPTURE_COMPARE_VALUE_H});

  always_comb begin
    cap_now = 1'b0;
    restart = 1'b0;
    case (mode_in)
      TMB_CAPTURE_FLAG_EVENT: cap_now = pos;
      TMB_CAPTURE_FLAG_FREQ: begin
        cap_now = pos;
        restart = pos;
      end
      TMB_CAPTURE_FLAG_PW: begin
        cap_now = neg;
        restart = pos;
      end
      TMB_CAPTURE_FLAG_FRQPW: begin
        cap_now = neg & (phase_r == TMB_PH_FIRST);
        restart = pos & (phase_r == TMB_PH_IDLE);
      end
      TMB_TIMEOUT: restart = pos;
      TMB_SINGLE_SHOT: restart = pos;
      default: begin
        cap_now = 1'b0;
        restart = 1'b0;
      end
    endcase
  end

  always_comb begin
    if (restart) begin
      cnt_nxt = TMB_RST_WORD;
    end else if (tick & top_mode & at_top) begin
      cnt_nxt = TMB_RST_WORD;
    end else if (tick & (mode_in == TMB_PWM8) & pwm_wrap) begin
      cnt_nxt = TMB_RST_WORD;
    end else if (tick) begin
      cnt_nxt = cnt_r + TMB_ONE;
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  always_comb begin
    run_nxt = run_r;
    if (!enable_in) begin
      run_nxt = 1'b0;
    end else begin
      case (mode_in)
        TMB_SINGLE_SHOT: begin
          if (pos) begin
            run_nxt = 1'b1;
          end else if (tick & at_top) begin
            run_nxt = 1'b0;
          end
        end
        TMB_TIMEOUT: begin
          if (pos) begin
            run_nxt = 1'b1;
          end else if (neg) begin
            run_nxt = 1'b0;
          end
        end
        TMB_CAPTURE_FLAG_FRQPW: begin
          if (pos & (phase_r == TMB_PH_IDLE)) begin
            run_nxt = 1'b1;
          end else if (pos & (phase_r == TMB_PH_SECOND)) begin
            run_nxt = 1'b0;
          end
        end
        default: run_nxt = 1'b1;
      endcase
    end
  end

  // frequency-and-width sequence: start, capture, stop; waits for disable
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_r <= TMB_PH_IDLE;
    end else if (!enable_in || mode_in != TMB_CAPTURE_FLAG_FRQPW) begin
      phase_r <= TMB_PH_IDLE;
    end else begin
      case (phase_r)
        TMB_PH_IDLE: if (pos) phase_r <= TMB_PH_FIRST;
        TMB_PH_FIRST: if (neg) phase_r <= TMB_PH_SECOND;
        TMB_PH_SECOND: if (pos) phase_r <= TMB_PH_DONE;
        default: phase_r <= phase_r;
      endcase
    end
  end

  assign flag_set = (cap_now & (mode_in != TMB_CAPTURE_FLAG_FRQPW))
    | (pos & (phase_r == TMB_PH_SECOND) & (mode_in == TMB_CAPTURE_FLAG_FRQPW))
    | (tick & top_mode & at_top)
    | (tick & (mode_in == TMB_PWM8) & (cnt_r[7:0] == capture_compare_value_r[15:8]));
  assign flag_clr = (req_in.wr & (req_in.addr == TMB_OFS_FLAGS) & req_in.wdata[TMB_BIT_CAPTURE_FLAG])
    | (req_in.rd & (req_in.addr == TMB_OFS_CAPTURE_COMPARE_VALUE_L) & capture_flag_mode);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flag_r <= 1'b0;
    end else if (flag_set) begin
      flag_r <= 1'b1;
    end else if (flag_clr) begin
      flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_r <= 1'b0;
      ev_prev_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      if (!frozen) ev_prev_r <= capture_event_in;
    end
  end

  // bus write wins over counting and restart in the same cycle
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_r <= TMB_RST_WORD;
    end else if (wr_cnt) begin
      cnt_r <= {temp_r, req_in.wdata};
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      capture_compare_value_r <= TMB_RST_WORD;
    end else if (wr_capture_compare_value && mode_in == TMB_PWM8) begin
      if (req_in.addr == TMB_OFS_CAPTURE_COMPARE_VALUE_L) capture_compare_value_r[7:0] <= req_in.wdata;
      else capture_compare_value_r[15:8] <= req_in.wdata;
    end else if (req_in.wr && req_in.addr == TMB_OFS_CAPTURE_COMPARE_VALUE_L) begin
      capture_compare_value_r <= {temp_r, req_in.wdata};
    end else if (cap_now) begin
      capture_compare_value_r <= cnt_r;
    end
  end

  // one buffer byte serves both 16-bit registers, so interleaving corrupts
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      temp_r <= TMB_RST_BYTE;
    end else if (req_in.wr) begin
      if (req_in.addr inside {TMB_OFS_TEMP, TMB_OFS_CNT_H}) begin
        temp_r <= req_in.wdata;
      end else if (req_in.addr == TMB_OFS_CAPTURE_COMPARE_VALUE_H && mode_in != TMB_PWM8) begin
        temp_r <= req_in.wdata;
      end
    end else if (req_in.rd) begin
      if (req_in.addr == TMB_OFS_CNT_L) temp_r <= cnt_r[15:8];
      else if (req_in.addr == TMB_OFS_CAPTURE_COMPARE_VALUE_L && mode_in != TMB_PWM8) temp_r <= capture_compare_value_r[15:8];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_in_debug_halt_r <= 1'b0;
    end else if (req_in.wr && req_in.addr == TMB_OFS_DBG) begin
      run_in_debug_halt_r <= req_in.wdata[TMB_BIT_RUN_IN_DEBUG_HALT];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_r <= TMB_RST_BYTE;
    end else if (req_in.rd) begin
      rdata_r <= TMB_RST_BYTE;
      case (req_in.addr)
        TMB_OFS_FLAGS: rdata_r[TMB_BIT_CAPTURE_FLAG] <= flag_r;
        TMB_OFS_STATUS: rdata_r[TMB_BIT_RUN] <= run_r;
        TMB_OFS_DBG: rdata_r[TMB_BIT_RUN_IN_DEBUG_HALT] <= run_in_debug_halt_r;
        TMB_OFS_TEMP: rdata_r <= temp_r;
        TMB_OFS_CNT_L: rdata_r <= cnt_r[7:0];
        TMB_OFS_CNT_H: rdata_r <= temp_r;
        TMB_OFS_CAPTURE_COMPARE_VALUE_L: rdata_r <= capture_compare_value_r[7:0];
        TMB_OFS_CAPTURE_COMPARE_VALUE_H: rdata_r <= (mode_in == TMB_PWM8) ? capture_compare_value_r[15:8] : temp_r;
        default: rdata_r <= TMB_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pwm_r <= 1'b0;
      top_r <= 1'b0;
    end else begin
      pwm_r <= (mode_in == TMB_PWM8) & run_r & (cnt_r[7:0] < capture_compare_value_r[15:8]);
      top_r <= tick & ((top_mode & at_top) | ((mode_in == TMB_PWM8) & pwm_wrap));
    end
  end

  assign rdata_out = rdata_r;
  assign run_out = run_r;
  assign capture_flag_out = flag_r;
  assign pwm_out = pwm_r;
  assign top_pulse_out = top_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_run_off;
    !enable_in |=> !run_out ##1 ($past(enable_in) || !run_out);
  endproperty
  a_run_off: assert property (p_run_off) else $error("run bit set while disabled");

  property p_freeze;
    frozen && !wr_cnt |=> $stable(cnt_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("count moved while frozen");

  property p_dbg_run;
    run_r && debug_halt_in && run_in_debug_halt_r && mode_in == TMB_PERIODIC
      && !at_top && !wr_cnt |=> cnt_r == $past(cnt_r) + TMB_ONE;
  endproperty
  a_dbg_run: assert property (p_dbg_run) else $error("count stopped in debug run");

  property p_temp_wr;
    req_in.wr && req_in.addr == TMB_OFS_TEMP |=> temp_r == $past(req_in.wdata);
  endproperty
  a_temp_wr: assert property (p_temp_wr) else $error("buffer byte not written");

  property p_cnt_read;
    req_in.rd && req_in.addr == TMB_OFS_CNT_L
      |=> rdata_out == $past(cnt_r[7:0]) && temp_r == $past(cnt_r[15:8]);
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("count low read wrong");

  property p_cnt_prio;
    wr_cnt |=> cnt_r == {$past(temp_r), $past(req_in.wdata)};
  endproperty
  a_cnt_prio: assert property (p_cnt_prio) else $error("count write lost");

  property p_capture;
    cap_now && !wr_capture_compare_value
      |=> capture_compare_value_r == $past(cnt_r) && (flag_r || $past(mode_in) == TMB_CAPTURE_FLAG_FRQPW);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_top;
    tick && top_mode && at_top && !wr_cnt && !restart |=> cnt_r == TMB_RST_WORD ##0 top_pulse_out;
  endproperty
  a_top: assert property (p_top) else $error("counter passed top");

  property p_pwm_indep;
    mode_in == TMB_PWM8 && req_in.wr && req_in.addr == TMB_OFS_CAPTURE_COMPARE_VALUE_H
      |=> capture_compare_value_r[7:0] == $past(capture_compare_value_r[7:0]) && capture_compare_value_r[15:8] == $past(req_in.wdata);
  endproperty
  a_pwm_indep: assert property (p_pwm_indep) else $error("pwm byte not independent");

  property p_flag_clr;
    flag_clr && !flag_set |=> !capture_flag_out;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("capture flag not cleared");
endmodule

// File: verif/test_tmb_timer.sv
`timescale 1ns/100ps
module test_tmb_timer;
  import tmb_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  tmb_req_t req_in = '0;
  tmb_mode_t mode_in = TMB_PERIODIC;
  logic enable_in = 1'b0;
  logic capture_event_in = 1'b0;
  logic debug_halt_in = 1'b0;
  logic [7:0] rdata_out;
  logic run_out;
  logic capture_flag_out;
  logic pwm_out;
  logic top_pulse_out;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] b;
  logic [7:0] c;
  logic [15:0] v;
  logic [15:0] w;
  logic [7:0] addrs [8] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h30};
  int n;
  int hi;

  tmb_timer tmb_timer_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .req_in(req_in),
    .mode_in(mode_in), .enable_in(enable_in), .capture_event_in(capture_event_in),
    .debug_halt_in(debug_halt_in), .rdata_out(rdata_out), .run_out(run_out),
    .capture_flag_out(capture_flag_out), .pwm_out(pwm_out), .top_pulse_out(top_pulse_out));

  initial begin
    forever #2.5 clk_in = ~clk_in;
  end

  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end

  function automatic logic [15:0] top_gap(input logic [15:0] top);
    return top + TMB_ONE;
  endfunction

  function automatic int pwm_high(input logic [7:0] duty, input int periods);
    return duty * periods;
  endfunction

  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    req_in <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    req_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_in);
    req_in <= '0;
    #1 d = rdata_out;
  endtask

  // high byte parks in the shared buffer, low byte commits the word
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a + 8'h01, d[15:8]);
    wr(a, d[7:0]);
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    logic [7:0] lo;
    logic [7:0] hb;
    rd(a, lo);
    rd(a + 8'h01, hb);
    d = {hb, lo};
  endtask

  task automatic pulse_gap(output int k);
    k = 0;
    do begin
      @(posedge clk_in);
      #1 k++;
    end while (top_pulse_out !== 1'b1 && k < 2000);
  endtask

  initial begin
    void'($urandom(32'hEF0828F7));
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    foreach (addrs[i]) begin
      rd(addrs[i], b);
      chk("reset value", 16'h0000, 16'(b));
    end
    b = 8'($urandom);
    wr(TMB_OFS_TEMP, b);
    rd(TMB_OFS_TEMP, c);
    chk("buffer", 16'(b), 16'(c));
    v = 16'($urandom);
    wr16(TMB_OFS_CNT_L, v);
    rd16(TMB_OFS_CNT_L, w);
    chk("count word", v, w);
    wr(TMB_OFS_STATUS, 8'hFF);
    rd(TMB_OFS_STATUS, b);
    chk("status stopped", 16'h0000, 16'(b));
    chk("run pin stopped", 16'h0000, 16'(run_out));
    v = 16'(20 + $urandom_range(20));
    wr16(TMB_OFS_CAPTURE_COMPARE_VALUE_L, v);
    rd16(TMB_OFS_CAPTURE_COMPARE_VALUE_L, w);
    chk("compare word", v, w);
    wr16(TMB_OFS_CNT_L, 16'h0000);
    @(posedge clk_in);
    enable_in <= 1'b1;
    pulse_gap(n);
    pulse_gap(n);
    chk("top interval", top_gap(v), 16'(n));
    chk("top flag", 16'h0001, 16'(capture_flag_out));
    wr(TMB_OFS_FLAGS, 8'h01);
    #1 chk("flag clear", 16'h0000, 16'(capture_flag_out));
    wr(TMB_OFS_STATUS, 8'h00);
    rd(TMB_OFS_STATUS, b);
    chk("status running", 16'h0001, 16'(b));
    chk("run pin running", 16'h0001, 16'(run_out));
    wr16(TMB_OFS_CAPTURE_COMPARE_VALUE_L, 16'hFFFF);
    v = {8'(16 + $urandom_range(100)), 8'($urandom_range(200))};
    wr16(TMB_OFS_CNT_L, v);
    rd16(TMB_OFS_CNT_L, w);
    chk("write beats count", 16'h0001, {15'h0000, (w - v) <= 16'h0006});
    @(posedge clk_in);
    debug_halt_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rd(TMB_OFS_CNT_L, b);
    rd(TMB_OFS_CNT_L, c);
    chk("frozen count", 16'h0000, 16'(8'(c - b)));
    wr(TMB_OFS_DBG, 8'h01);
    rd(TMB_OFS_CNT_L, b);
    rd(TMB_OFS_CNT_L, c);
    chk("debug run count", 16'h0002, 16'(8'(c - b)));
    @(posedge clk_in);
    debug_halt_in <= 1'b0;
    mode_in <= TMB_CAPTURE_FLAG_EVENT;
    wr(TMB_OFS_DBG, 8'h00);
    wr(TMB_OFS_FLAGS, 8'h01);
    wr16(TMB_OFS_CNT_L, 16'h0100);
    @(posedge clk_in);
    capture_event_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    #1 chk("capture flag", 16'h0001, 16'(capture_flag_out));
    rd16(TMB_OFS_CAPTURE_COMPARE_VALUE_L, w);
    chk("captured count", 16'h0001, {15'h0000, (w - 16'h0100) <= 16'h0006});
    chk("flag cleared by read", 16'h0000, 16'(capture_flag_out));
    @(posedge clk_in);
    capture_event_in <= 1'b0;
    enable_in <= 1'b0;
    mode_in <= TMB_PWM8;
    b = 8'(8 + $urandom_range(32));
    c = 8'(1 + $urandom_range(int'(b) - 2));
    wr16(TMB_OFS_CNT_L, 16'h0000);
    wr(TMB_OFS_CAPTURE_COMPARE_VALUE_L, b);
    wr(TMB_OFS_CAPTURE_COMPARE_VALUE_H, c);
    rd(TMB_OFS_CAPTURE_COMPARE_VALUE_L, v[7:0]);
    rd(TMB_OFS_CAPTURE_COMPARE_VALUE_H, v[15:8]);
    chk("pwm bytes", {c, b}, v);
    @(posedge clk_in);
    enable_in <= 1'b1;
    pulse_gap(n);
    hi = 0;
    repeat (4 * (int'(b) + 1)) begin
      @(posedge clk_in);
      #1 hi += int'(pwm_out === 1'b1);
    end
    chk("pwm high cycles", 16'(pwm_high(c, 4)), 16'(hi));
    // single shot: one edge takes the event, then counts zero to top and stops
    @(posedge clk_in);
    enable_in <= 1'b0;
    mode_in <= TMB_SINGLE_SHOT;
    v = 16'(10 + $urandom_range(30));
    wr16(TMB_OFS_CAPTURE_COMPARE_VALUE_L, v);
    wr(TMB_OFS_FLAGS, 8'h01);
    @(posedge clk_in);
    enable_in <= 1'b1;
    capture_event_in <= 1'b1;
    pulse_gap(n);
    chk("single shot time", v + 16'h0002, 16'(n));
    chk("single shot flag", 16'h0001, 16'(capture_flag_out));
    repeat (2) @(posedge clk_in);
    #1 chk("single shot run pin", 16'h0000, 16'(run_out));
    rd(TMB_OFS_CNT_L, b);
    chk("single shot stopped", 16'h0000, 16'(b));
    // pulse width: rise restarts at zero, fall captures one less than the width
    wr(TMB_OFS_FLAGS, 8'h01);
    capture_event_in <= 1'b0;
    @(posedge clk_in);
    mode_in <= TMB_CAPTURE_FLAG_PW;
    capture_event_in <= 1'b1;
    hi = 4 + $urandom_range(20);
    repeat (hi) @(posedge clk_in);
    capture_event_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 chk("width flag", 16'h0001, 16'(capture_flag_out));
    rd16(TMB_OFS_CAPTURE_COMPARE_VALUE_L, w);
    chk("pulse width", 16'(hi - 1), w);
    chk("width flag read", 16'h0000, 16'(capture_flag_out));
    stop_test();
  end
endmodule
